// File: design/timer_prescaler_and_flags.sv
`timescale 1ns/1ps
// Behaviour
// - Capture flag sets on each capture edge seen on the capture input pin.
// - With capture register as top, capture flag sets when counter reaches top.
// - Four flags clear on interrupt vector execution or a written one.
// - Compare B flag sets one timer clock after counter equals compare B.
// - Compare A flag sets one timer clock after counter equals compare A.
// - Force-compare strobes never set compare match flags.
// - Normal and clear-on-compare modes set overflow flag on timer overflow.
// - Flag register bits 7, 6, 4, 3 always read zero.
// - Select 1 passes system clock; selects 2 to 5 use taps /8 /64 /256 /1024.
// - Prescaler runs freely, shared by both timers, each picks its tap.
// - First prescaled count comes 1 to N+1 cycles after enabling.
// - Prescaler reset restarts the period for both timers.
// - External clock pin sampled each system clock through synchroniser registers.
// - Select 7 counts rising edges, select 6 counts falling edges.
// - Counter updates 2.5 to 3.5 cycles after an external edge.
// - External edges clock the counter without any prescaler division.
// - In sync mode both prescaler reset bits hold as written.
// - Writing sync mode zero clears both prescaler reset bits.
// - Sync prescaler reset bit resets shared prescaler, self-clears outside sync mode.
module timer_prescaler_and_flags (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [timer_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [timer_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [1:0] external_clock_pin,
   input wire logic capture_input_pin,
   input wire timer_pkg::timer1_view_t timer1_view,
   input wire logic [3:0] vector_ack,
   output logic [1:0] timer_tick,
   output logic [7:0] irq_flags,
   output logic sync_prescaler_reset,
   output logic async_prescaler_reset
);
   import timer_pkg::*;

   // ****************************************
   // Bus slave state
   // ****************************************
   logic aw_full;
   logic w_full;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_strb_q;
   logic [7:0] flags;
   logic sync_mode;
   logic [7:0] clksel;
   logic [PRESCALE_W-1:0] prescale;
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic [1:0] pin_prev;
   logic [1:0] cap_meta;
   logic cap_prev;

   wire aw_take = awvalid & awready;
   wire w_take = wvalid & wready;
   wire have_aw = aw_full | aw_take;
   wire have_w = w_full | w_take;
   wire wr_fire = have_aw & have_w;
   wire [ADDR_W-1:0] wr_addr = aw_take ? awaddr : aw_addr_q;
   wire [7:0] wr_data = w_take ? wdata[7:0] : w_data_q;
   wire wr_lane = w_take ? wstrb[0] : w_strb_q;
   wire wr_flags_hit = wr_addr == ADDR_FLAGS;
   wire wr_global_hit = wr_addr == ADDR_GLOBAL;
   wire wr_clksel_hit = wr_addr == ADDR_CLKSEL;
   wire wr_mapped = wr_flags_hit | wr_global_hit | wr_clksel_hit;
   wire wr_flags = wr_fire & wr_flags_hit & wr_lane;
   wire wr_global = wr_fire & wr_global_hit & wr_lane;
   wire wr_clksel = wr_fire & wr_clksel_hit & wr_lane;
   wire next_aw_full = have_aw & ~wr_fire;
   wire next_w_full = have_w & ~wr_fire;
   wire next_bvalid = wr_fire | (bvalid & ~bready);
   wire ar_take = arvalid & arready;
   wire next_rvalid = ar_take | (rvalid & ~rready);
   wire rd_flags_hit = araddr == ADDR_FLAGS;
   wire rd_global_hit = araddr == ADDR_GLOBAL;
   wire rd_clksel_hit = araddr == ADDR_CLKSEL;
   wire rd_mapped = rd_flags_hit | rd_global_hit | rd_clksel_hit;
   wire [7:0] global_view = {sync_mode, 5'b0_0000, async_prescaler_reset, sync_prescaler_reset};
   wire [7:0] rd_byte = rd_flags_hit ? (flags & FLAGS_MASK) :
      rd_global_hit ? global_view :
      rd_clksel_hit ? clksel : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         if (aw_take) begin
            aw_addr_q <= awaddr;
         end
         if (w_take) begin
            w_data_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
         end
         // Ready drops while a response is owed, so one write is in flight
         awready <= ~next_aw_full & ~next_bvalid;
         wready <= ~next_w_full & ~next_bvalid;
         bvalid <= next_bvalid;
         if (wr_fire) begin
            bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         arready <= ~next_rvalid;
         rvalid <= next_rvalid;
         if (ar_take) begin
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // Global control and prescaler
   // ****************************************
   // A write always lands; afterwards the reset bits drop unless sync mode holds them
   wire next_sync_mode = wr_global ? wr_data[GLOBAL_SYNC_MODE] : sync_mode;
   wire next_psr_sync = wr_global ? wr_data[GLOBAL_PSR_SYNC] : (sync_prescaler_reset & sync_mode);
   wire next_psr_async = wr_global ? wr_data[GLOBAL_PSR_ASYNC] : (async_prescaler_reset & sync_mode);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_mode <= GLOBAL_RESET[GLOBAL_SYNC_MODE];
         sync_prescaler_reset <= GLOBAL_RESET[GLOBAL_PSR_SYNC];
         async_prescaler_reset <= GLOBAL_RESET[GLOBAL_PSR_ASYNC];
         clksel <= CLKSEL_RESET;
         prescale <= '0;
      end else begin
         sync_mode <= next_sync_mode;
         sync_prescaler_reset <= next_psr_sync;
         async_prescaler_reset <= next_psr_async;
         if (wr_clksel) begin
            clksel <= wr_data & CLKSEL_MASK;
         end
         // One counter for both timers, blind to either clock select
         if (sync_prescaler_reset) begin
            prescale <= '0;
         end else begin
            prescale <= prescale + 1'b1;
         end
      end
   end

   // Tap strobes fire once per period; held off while the prescaler is in reset
   wire run = ~sync_prescaler_reset;
   wire tap8 = run & (&prescale[2:0]);
   wire tap64 = run & (&prescale[5:0]);
   wire tap256 = run & (&prescale[7:0]);
   wire tap1024 = run & (&prescale[9:0]);

   // ****************************************
   // Per-timer clock select
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_timer
         clock_select_t sel;
         logic rise;
         logic fall;
         logic tick;
         assign sel = clock_select_t'(clksel[4*i +: 3]);
         assign rise = pin_sync[i] & ~pin_prev[i];
         assign fall = ~pin_sync[i] & pin_prev[i];
         always_comb begin
            unique case (sel)
               CS_STOP: tick = 1'b0;
               CS_DIV1: tick = 1'b1;
               CS_DIV8: tick = tap8;
               CS_DIV64: tick = tap64;
               CS_DIV256: tick = tap256;
               CS_DIV1024: tick = tap1024;
               CS_EXT_FALL: tick = fall;
               CS_EXT_RISE: tick = rise;
            endcase
         end
         // The latch stage is modelled by the first flop; edge sampled on the second
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pin_meta[i] <= 1'b0;
               pin_sync[i] <= 1'b0;
               pin_prev[i] <= 1'b0;
               timer_tick[i] <= 1'b0;
            end else begin
               pin_meta[i] <= external_clock_pin[i];
               pin_sync[i] <= pin_meta[i];
               pin_prev[i] <= pin_sync[i];
               timer_tick[i] <= tick;
            end
         end
      end
   endgenerate

   // ****************************************
   // Interrupt flags
   // ****************************************
   wire [3:0] mode = timer1_view.waveform_mode_bits;
   wire cap_is_top = (mode == 4'h8) | (mode == 4'ha) | (mode == WGM_CTC_CAP) | (mode == 4'he);
   wire tick1 = timer_tick[1];
   wire [15:0] cnt = timer1_view.counter_value;
   wire cap_sync = cap_meta[1];
   wire cap_edge = timer1_view.capture_edge_rising ? (cap_sync & ~cap_prev) : (~cap_sync & cap_prev);
   wire set_cap = cap_is_top ? (tick1 & (cnt == timer1_view.capture_value_register)) : cap_edge;
   // Only a comparator match sets these; force strobes have no path here
   wire set_cmp_a = tick1 & (cnt == timer1_view.compare_a_register);
   wire set_cmp_b = tick1 & (cnt == timer1_view.compare_b_register);
   wire plain_mode = (mode == WGM_NORMAL) | (mode == WGM_CTC_CMP) | (mode == WGM_CTC_CAP);
   wire set_ovf = plain_mode ? (tick1 & (cnt == COUNT_MAX)) : timer1_view.overflow_event;
   wire [7:0] flag_set = {2'b00, set_cap, 2'b00, set_cmp_b, set_cmp_a, set_ovf};
   wire [7:0] ack_clr = {2'b00, vector_ack[3], 2'b00, vector_ack[2], vector_ack[1], vector_ack[0]};
   wire [7:0] sw_clr = wr_flags ? wr_data : 8'h00;
   wire [7:0] next_flags = ((flags & ~(sw_clr | ack_clr)) | flag_set) & FLAGS_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_meta <= 2'b00;
         cap_prev <= 1'b0;
         flags <= FLAGS_RESET;
         irq_flags <= FLAGS_RESET;
      end else begin
         cap_meta <= {cap_meta[0], capture_input_pin};
         cap_prev <= cap_sync;
         flags <= next_flags;
         irq_flags <= next_flags;
      end
   end

   // Protection bits are accepted but carry no meaning in this block
   wire unused_prot = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};
endmodule : timer_prescaler_and_flags

// File: shared/timer_pkg.sv
package timer_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_FLAGS = 10'h036;
   localparam logic [9:0] IDX_GLOBAL = 10'h043;
   localparam logic [9:0] IDX_CLKSEL = 10'h044;
   localparam logic [11:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
   localparam logic [11:0] ADDR_GLOBAL = {IDX_GLOBAL, 2'b00};
   localparam logic [11:0] ADDR_CLKSEL = {IDX_CLKSEL, 2'b00};
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] GLOBAL_RESET = 8'h00;
   localparam logic [7:0] CLKSEL_RESET = 8'h00;
   localparam logic [7:0] FLAGS_MASK = 8'h27;
   localparam logic [7:0] CLKSEL_MASK = 8'h77;
   localparam int FLAG_CAPTURE = 5;
   localparam int FLAG_CMP_B = 2;
   localparam int FLAG_CMP_A = 1;
   localparam int FLAG_OVF = 0;
   localparam int GLOBAL_SYNC_MODE = 7;
   localparam int GLOBAL_PSR_ASYNC = 1;
   localparam int GLOBAL_PSR_SYNC = 0;
   localparam int CLKSEL_T0_LSB = 0;
   localparam int CLKSEL_T1_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ****************************************
   // Timing and modes
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int PRESCALE_W = 10;
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_CTC_CMP = 4'h4;
   localparam logic [3:0] WGM_CTC_CAP = 4'hc;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
   } clock_select_t;
   typedef struct packed {
      logic [15:0] counter_value;
      logic [15:0] compare_a_register;
      logic [15:0] compare_b_register;
      logic [15:0] capture_value_register;
      logic [3:0] waveform_mode_bits;
      logic overflow_event;
      logic capture_edge_rising;
   } timer1_view_t;
endpackage : timer_pkg

// File: verification/ext_clock_source.sv
`timescale 1ns/1ps
// ****************************************
// External clock source on the timer pins
// ****************************************
module ext_clock_source (
   input wire logic aclk,
   input wire logic run,
   output logic [1:0] external_clock_pin
);
   logic [1:0] phase;
   // Opposite phases on the two pins; half period of three cycles leaves margin below a third
   initial begin
      external_clock_pin = 2'b01;
      phase = 2'b00;
   end
   always @(posedge aclk) begin
      if (run) begin
         phase <= (phase == 2'b10) ? 2'b00 : phase + 2'b01;
         if (phase == 2'b10) external_clock_pin <= ~external_clock_pin;
      end
   end
endmodule : ext_clock_source

// File: verification/tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module tb_top;
   import timer_pkg::*;
   localparam timer1_view_t QUIET = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, WGM_CTC_CMP, 1'b0, 1'b1};
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic capture_input_pin = 0, run = 0, awready, wready, bvalid, arready, rvalid, sync_prescaler_reset;
   logic async_prescaler_reset;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] vector_ack = 0;
   logic [1:0] bresp, rresp, r, timer_tick, external_clock_pin, pq;
   logic [7:0] irq_flags;
   timer1_view_t timer1_view = QUIET, v;
   int fails = 0, checks = 0, seed = 32'h3528, t0, t1, ri, fa;
   always #(CLK_PERIOD_NS / 2) aclk = ~aclk;
   ext_clock_source u_src (.aclk, .run, .external_clock_pin);
   timer_prescaler_and_flags u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'b000), .wvalid,
      .wready, .wdata, .wstrb(4'h1), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'b000),
      .rvalid, .rready, .rdata, .rresp, .external_clock_pin, .capture_input_pin, .timer1_view, .vector_ack,
      .timer_tick, .irq_flags, .sync_prescaler_reset, .async_prescaler_reset);
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] dat);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, dat};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic rflags(input logic [7:0] exp);
      rd(ADDR_FLAGS, d, r);
      chk("flag register", {24'h00_0000, exp}, d);
      chk("flag port", {24'h00_0000, exp}, {24'h00_0000, irq_flags});
   endtask : rflags
   task automatic cnt(input int n);
      repeat (n) begin
         @(posedge aclk);
         t0 += timer_tick[0];
         t1 += timer_tick[1];
         ri += external_clock_pin[1] & ~pq[1];
         fa += ~external_clock_pin[1] & pq[1];
         pq = external_clock_pin;
      end
   endtask : cnt
   function automatic int div(input int s);
      case (s)
         1: return 1;
         2: return 8;
         3: return 64;
         4: return 256;
         default: return 1024;
      endcase
   endfunction : div
   function automatic logic [7:0] exp_flags(input timer1_view_t x);
      logic [3:0] m;
      m = x.waveform_mode_bits;
      exp_flags = 8'h00;
      exp_flags[FLAG_CMP_A] = x.counter_value == x.compare_a_register;
      exp_flags[FLAG_CMP_B] = x.counter_value == x.compare_b_register;
      exp_flags[FLAG_OVF] = (m == WGM_NORMAL || m == WGM_CTC_CMP || m == WGM_CTC_CAP) ?
         x.counter_value == COUNT_MAX : x.overflow_event;
      exp_flags[FLAG_CAPTURE] = m[3] && !m[0] && x.counter_value == x.capture_value_register;
   endfunction : exp_flags
   task automatic final_report;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   initial begin
      #(20000 * CLK_PERIOD_NS);
      fails++;
      final_report;
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rflags(FLAGS_RESET);
      rd(ADDR_GLOBAL, d, r);
      chk("global reset", GLOBAL_RESET, d);
      rd(12'h004, d, r);
      chk("unmapped resp", RESP_SLVERR, r);
      wr(12'h004, 8'h00);
      chk("unmapped bresp", RESP_SLVERR, bresp);
      for (int s = 1; s < 6; s++) begin
         wr(ADDR_CLKSEL, 8'((s % 5 + 1) * 16 + s));
         repeat (4) @(posedge aclk);
         t0 = 0;
         t1 = 0;
         cnt(1024);
         chk("tick0 count", 1024 / div(s), t0);
         chk("tick1 count", 1024 / div(s % 5 + 1), t1);
      end
      wr(ADDR_CLKSEL, 8'h12);
      wr(ADDR_GLOBAL, 8'h83);
      rd(ADDR_GLOBAL, d, r);
      chk("global sync", 32'h0000_0083, d);
      chk("reset level", 1, sync_prescaler_reset);
      chk("async level", 1, async_prescaler_reset);
      t0 = 0;
      cnt(64);
      chk("held ticks", 0, t0);
      wr(ADDR_GLOBAL, 8'h00);
      rd(ADDR_GLOBAL, d, r);
      chk("global release", 0, d);
      chk("async release", 0, async_prescaler_reset);
      wr(ADDR_GLOBAL, 8'h01);
      rd(ADDR_GLOBAL, d, r);
      chk("global selfclear", 0, d);
      for (int i = 0; i < 24; i++) begin
         v.counter_value = i[2] ? COUNT_MAX : 16'($random(seed));
         v.compare_a_register = v.counter_value + 16'($random(seed) % 2);
         v.compare_b_register = v.counter_value + 16'($random(seed) % 2);
         v.capture_value_register = v.counter_value + 16'($random(seed) % 2);
         v.waveform_mode_bits = {i[1:0], 2'b00};
         v.overflow_event = 1'($random(seed));
         v.capture_edge_rising = 1'b1;
         @(posedge aclk);
         timer1_view <= v;
         @(posedge aclk);
         timer1_view <= QUIET;
         rflags(exp_flags(v));
         wr(ADDR_FLAGS, 8'h00);
         rflags(exp_flags(v));
         if (i[0]) wr(ADDR_FLAGS, 8'hff);
         else begin
            @(posedge aclk);
            vector_ack <= 4'hf;
            @(posedge aclk);
            vector_ack <= 4'h0;
         end
         rflags(8'h00);
      end
      @(posedge aclk);
      capture_input_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      rflags(8'h20);
      for (int e = 7; e > 5; e--) begin
         wr(ADDR_CLKSEL, 8'(e * 17));
         repeat (6) @(posedge aclk);
         t1 = 0;
         ri = 0;
         fa = 0;
         pq = external_clock_pin;
         run <= 1'b1;
         cnt(60);
         run <= 1'b0;
         cnt(10);
         chk("external ticks", e == 7 ? ri : fa, t1);
      end
      final_report;
   end
endmodule : tb_top

// File: verification/timer_prescaler_and_flags_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Flag register checker
// ****************************************
module timer_prescaler_and_flags_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic wvalid,
   input wire timer_pkg::timer1_view_t timer1_view,
   input wire logic [3:0] vector_ack,
   input wire logic [1:0] timer_tick,
   input wire logic [7:0] irq_flags
);
   import timer_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic [15:0] cnt = timer1_view.counter_value;
   wire logic [3:0] mode = timer1_view.waveform_mode_bits;
   wire logic hit_a = timer_tick[1] && cnt == timer1_view.compare_a_register;
   wire logic hit_b = timer_tick[1] && cnt == timer1_view.compare_b_register;
   wire logic ovf_mode = mode == WGM_NORMAL || mode == WGM_CTC_CMP || mode == WGM_CTC_CAP;
   sequence cap_top_hit;
      mode == WGM_CTC_CAP && timer_tick[1] && cnt == timer1_view.capture_value_register;
   endsequence
   chk_rsvd_zero: assert property (irq_flags[7:6] == 2'b00 && irq_flags[4:3] == 2'b00)
      else $error("reserved flag bit read as one");
   chk_cmpa_set: assert property (hit_a |=> irq_flags[FLAG_CMP_A])
      else $error("compare a flag not set after match");
   chk_cmpb_set: assert property (hit_b |=> irq_flags[FLAG_CMP_B])
      else $error("compare b flag not set after match");
   chk_ovf_set: assert property (timer_tick[1] && ovf_mode && cnt == COUNT_MAX |=> irq_flags[FLAG_OVF])
      else $error("overflow flag not set at wrap");
   chk_cap_top: assert property (cap_top_hit |=> irq_flags[FLAG_CAPTURE])
      else $error("capture flag not set at top");
   chk_vector_clear: assert property (vector_ack[1] && !hit_a |=> !irq_flags[FLAG_CMP_A])
      else $error("compare a flag kept after vector");
   chk_no_force: assert property ($rose(irq_flags[FLAG_CMP_B]) |-> $past(hit_b))
      else $error("compare b flag set without match");
   chk_zero_keep: assert property (irq_flags[2] && !vector_ack[2] && !awvalid && !wvalid |=> irq_flags[2])
      else $error("compare b flag lost without clear");
endmodule : timer_prescaler_and_flags_asserts
bind timer_prescaler_and_flags timer_prescaler_and_flags_asserts u_chk (.aclk, .aresetn, .awvalid, .wvalid,
   .timer1_view, .vector_ack, .timer_tick, .irq_flags);
